/* logic/rx_output_node.sv */
// Standalone receive output port, diagnostic flag and network time
// Function
// - Output updates only on packets addressed here
// - Word copy must match word near end
// - Latch loads only on good packets
// - Port floats until first accepted packet, except bit 0 in strobe mode
// - Trigger 111 turns bit 0 into strobe
// - Strobe pulses on each latch update
// - In that mode bits 15..1 carry data
// - Strobe always driven, high after reset
// - Low diagnostic pin enables diagnostic mode
// - Diagnostic mode forces highest identifier 31
// - Diagnostic source packet sets flag bit
// - Flag floats until qualifying packet
// - Page size picks diagnostic identifier
// - Sixteen bit network time, adjusted by master
// - Prescale 1:32 doubling up to 1:4096
// - Own identifier equal master identifier means master
// - Slave presets time on first master packet
// - Slave trims rate: slows when ahead by 2 or more, speeds up when behind
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rx_output_node (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Received byte stream
  input wire rxnode_pkg::rx_beat_t rx_beat_i,
  // Diagnostic pin
  input wire logic diag_enable_n_i,
  // Output port, enables active low
  output logic [15:0] data_out_lines_o,
  output logic [15:0] data_out_lines_oe_n_o,
  // Flag pin, enable active low
  output logic flag_latch_out_o,
  output logic flag_latch_out_oe_n_o,
  // Network state
  output logic [15:0] network_time_o,
  output logic [4:0] highest_node_id_o,
  output logic time_master_o,
  output logic diag_mode_o
);
  import rxnode_pkg::*;

  // Configuration registers
  logic [2:0] tx_trigger_select_reg;
  logic [1:0] page_size_sel_reg;
  logic [2:0] time_prescale_sel_reg;
  logic [4:0] own_node_id_reg;
  logic [4:0] time_master_id_reg;
  logic [4:0] cfg_max_id_reg;
  // Bus state
  logic wait_reg;
  logic [31:0] rdata_reg;
  // Receive and output state
  logic [15:0] latch_reg;
  logic driven_reg;
  logic [3:0] strobe_cnt_reg;
  logic [15:0] data_out_reg;
  logic [15:0] data_oe_n_reg;
  logic flag_reg;
  logic flag_oe_n_reg;
  logic preset_done_reg;
  logic [4:0] highest_id_reg;
  logic master_reg;
  logic diag_mode_reg;
  logic diag_sync1_reg;
  logic diag_sync2_reg;
  // Submodule outputs
  logic sum_done;
  rx_summary_t sum;
  logic [15:0] net_time;

  // Bus decode
  wire bus_req = avs_read_i || avs_write_i;
  wire bus_go = avs_write_i && !wait_reg;
  wire [4:0] word_addr = {avs_address_i[4:2], 2'b00};
  wire wr_ctrl = bus_go && word_addr == OFS_CTRL;
  wire wr_node = bus_go && word_addr == OFS_NODE;
  wire resync = (wr_ctrl && avs_writedata_i[CTRL_RESYNC_BIT]) || wr_node;
  wire wait_next = !(bus_req && wait_reg);

  // Read mux, unmapped reads give zero
  wire [31:0] rd_ctrl = {21'h000000, time_prescale_sel_reg, 2'b00, page_size_sel_reg,
                         1'b0, tx_trigger_select_reg};
  wire [31:0] rd_node = {11'h000, cfg_max_id_reg, 3'h0, time_master_id_reg,
                         3'h0, own_node_id_reg};
  wire [31:0] rd_status = {19'h00000, highest_id_reg, 3'h0, diag_mode_reg, master_reg,
                           preset_done_reg, !flag_oe_n_reg, driven_reg};
  wire [31:0] rdata_next = (word_addr == OFS_CTRL) ? rd_ctrl :
                           (word_addr == OFS_NODE) ? rd_node :
                           (word_addr == OFS_STATUS) ? rd_status :
                           (word_addr == OFS_TIME) ? {16'h0000, net_time} :
                           (word_addr == OFS_LATCH) ? {16'h0000, latch_reg} : 32'h00000000;

  // Waitrequest falls one cycle after a request, for one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      if (avs_read_i && wait_reg) rdata_reg <= rdata_next;
    end
  end

  // Control register writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_trigger_select_reg <= TRIG_RST;
      page_size_sel_reg <= PAGE_RST;
      time_prescale_sel_reg <= PRE_RST;
    end else if (wr_ctrl) begin
      tx_trigger_select_reg <= avs_writedata_i[CTRL_TRIG_LSB +: 3];
      page_size_sel_reg <= avs_writedata_i[CTRL_PAGE_LSB +: 2];
      time_prescale_sel_reg <= avs_writedata_i[CTRL_PRE_LSB +: 3];
    end
  end

  // Node identifier writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_node_id_reg <= OWN_ID_RST;
      time_master_id_reg <= MASTER_ID_RST;
      cfg_max_id_reg <= MAX_ID_RST;
    end else if (wr_node) begin
      own_node_id_reg <= avs_writedata_i[NODE_OWN_LSB +: 5];
      time_master_id_reg <= avs_writedata_i[NODE_MASTER_LSB +: 5];
      cfg_max_id_reg <= avs_writedata_i[NODE_MAX_LSB +: 5];
    end
  end

  // Packet tail tracker
  pkt_tail u_tail (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .beat_i(rx_beat_i),
    .done_o(sum_done),
    .sum_o(sum)
  );

  // Acceptance checks for the output port
  wire addr_ok = sum.dest_id == {3'h0, own_node_id_reg};
  wire dup_ok = sum.word_a == sum.word_b;
  wire accept = sum_done && addr_ok && dup_ok && sum.crc_ok && sum.long_enough;
  wire mode_ext = tx_trigger_select_reg == TRIG_EXTERNAL;
  wire strobe_n = strobe_cnt_reg == 4'h0;

  // Output latch and strobe timer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_reg <= 16'h0000;
      driven_reg <= 1'b0;
      strobe_cnt_reg <= 4'h0;
    end else begin
      if (accept) latch_reg <= sum.word_a;
      if (accept) driven_reg <= 1'b1;
      if (accept && mode_ext) strobe_cnt_reg <= STROBE_LOW_CYCLES;
      else if (!strobe_n) strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
    end
  end

  // Pin drivers; bit 0 is the strobe in external trigger mode
  wire [15:0] out_next = {latch_reg[15:1], mode_ext ? strobe_n : latch_reg[0]};
  wire [15:0] oe_n_next = {{15{!driven_reg}}, mode_ext ? 1'b0 : !driven_reg};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_out_reg <= 16'h0001;
      data_oe_n_reg <= 16'hFFFF;
    end else begin
      data_out_reg <= out_next;
      data_oe_n_reg <= oe_n_next;
    end
  end

  // Diagnostic pin synchroniser
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_sync1_reg <= 1'b1;
      diag_sync2_reg <= 1'b1;
    end else begin
      diag_sync1_reg <= diag_enable_n_i;
      diag_sync2_reg <= diag_sync1_reg;
    end
  end

  // Diagnostic identifier from page size, highest identifier override
  wire [5:0] diag_id_wide = (DIAG_ID_BASE << page_size_sel_reg) - 6'h01;
  wire [4:0] diag_id = diag_id_wide[4:0];
  wire diag_on = !diag_sync2_reg;
  wire [4:0] highest_next = diag_on ? DIAG_MAX_ID : cfg_max_id_reg;
  wire from_diag = sum_done && sum.crc_ok && sum.sid == {3'h0, diag_id};

  // Flag pin and node status
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
      flag_oe_n_reg <= 1'b1;
      highest_id_reg <= MAX_ID_RST;
      master_reg <= 1'b0;
      diag_mode_reg <= 1'b0;
    end else begin
      if (from_diag) flag_reg <= sum.last_byte[7];
      if (from_diag) flag_oe_n_reg <= 1'b0;
      highest_id_reg <= highest_next;
      master_reg <= own_node_id_reg == time_master_id_reg;
      diag_mode_reg <= diag_on;
    end
  end

  // Time master tracking
  wire is_master = own_node_id_reg == time_master_id_reg;
  wire from_master = sum_done && sum.crc_ok && !is_master
                     && sum.sid == {3'h0, time_master_id_reg};
  wire time_load = from_master && !preset_done_reg;
  wire [15:0] time_diff = net_time - sum.time_word;
  wire diff_neg = time_diff[15];
  wire time_slow = from_master && preset_done_reg && !diff_neg
                   && time_diff >= 16'h0002;
  wire time_fast = from_master && preset_done_reg && diff_neg;

  // First-load flag; a load in the resync cycle still counts
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preset_done_reg <= 1'b0;
    end else begin
      preset_done_reg <= time_load || (preset_done_reg && !resync);
    end
  end

  // Network time counter
  net_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .prescale_sel_i(time_prescale_sel_reg),
    .load_i(time_load),
    .load_value_i(sum.time_word),
    .slow_i(time_slow),
    .fast_i(time_fast),
    .time_o(net_time)
  );

  // Outputs
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign data_out_lines_o = data_out_reg;
  assign data_out_lines_oe_n_o = data_oe_n_reg;
  assign flag_latch_out_o = flag_reg;
  assign flag_latch_out_oe_n_o = flag_oe_n_reg;
  assign network_time_o = net_time;
  assign highest_node_id_o = highest_id_reg;
  assign time_master_o = master_reg;
  assign diag_mode_o = diag_mode_reg;

  // Checks
  AST_ADDR_FILTER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sum_done && !addr_ok) |=> $stable(latch_reg))
    else $error("latch changed on foreign packet");
  AST_DUP_FILTER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sum_done && !dup_ok) |=> $stable(latch_reg))
    else $error("latch changed on word mismatch");
  AST_LATCH_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    accept |=> (latch_reg == $past(sum.word_a)) && driven_reg)
    else $error("latch missed accepted word");
  AST_HIZ_UNTIL_ACCEPT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !driven_reg |=> (&data_oe_n_reg[15:1]))
    else $error("port driven before first accept");
  AST_STROBE_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (accept && mode_ext) ##1 mode_ext |=> !data_out_reg[0] && !data_oe_n_reg[0])
    else $error("strobe missing after update");
  AST_STROBE_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (mode_ext && strobe_n) |=> data_out_reg[0] && !data_oe_n_reg[0])
    else $error("strobe not high while idle");
  AST_UPPER_BITS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    driven_reg |=> data_out_reg[15:1] == $past(latch_reg[15:1]))
    else $error("port upper bits differ from latch");
  AST_DIAG_MAX: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    diag_on |=> highest_id_reg == DIAG_MAX_ID)
    else $error("highest id not forced in diagnostic mode");
  AST_FLAG_LATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    from_diag |=> flag_reg == $past(sum.last_byte[7]) && !flag_oe_n_reg)
    else $error("flag not taken from diagnostic packet");
  AST_TIME_PRESET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    time_load |=> net_time == $past(sum.time_word) && preset_done_reg)
    else $error("slave time not preset");
  AST_CRC_FILTER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sum_done && !sum.crc_ok) |=> $stable(latch_reg))
    else $error("latch changed on bad check sum");
  AST_LATCH_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !accept |=> $stable(latch_reg))
    else $error("latch changed without accept");
  AST_PORT_DRIVEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    driven_reg |=> (data_oe_n_reg[15:1] == 15'h0000))
    else $error("port not driven after accept");
  AST_BIT0_DATA: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !mode_ext |=> (data_out_reg[0] == $past(latch_reg[0])))
    else $error("bit 0 not data outside strobe mode");
  AST_BIT0_FLOAT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!mode_ext && !driven_reg) |=> data_oe_n_reg[0])
    else $error("bit 0 driven before first accept");
  AST_STROBE_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (strobe_n && !(accept && mode_ext)) |=> strobe_n)
    else $error("strobe without latch update");
  AST_STROBE_DRIVEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mode_ext |=> !data_oe_n_reg[0])
    else $error("strobe pin not driven");
  AST_DIAG_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !diag_on |=> (highest_id_reg == $past(cfg_max_id_reg)))
    else $error("highest id not configured value");
  AST_DIAG_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    diag_on |=> diag_mode_reg)
    else $error("diagnostic mode not shown");
  AST_FLAG_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !from_diag |=> $stable(flag_reg))
    else $error("flag changed without diagnostic packet");
  AST_FLAG_HIZ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (flag_oe_n_reg && !from_diag) |=> flag_oe_n_reg)
    else $error("flag driven before diagnostic packet");
  AST_DIAG_ID_P3: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (page_size_sel_reg == 2'h3) |-> (diag_id == 5'h1F))
    else $error("diagnostic id wrong for page code 3");
  AST_DIAG_ID_P2: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (page_size_sel_reg == 2'h2) |-> (diag_id == 5'h0F))
    else $error("diagnostic id wrong for page code 2");
  AST_DIAG_ID_P1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (page_size_sel_reg == 2'h1) |-> (diag_id == 5'h07))
    else $error("diagnostic id wrong for page code 1");
  AST_DIAG_ID_P0: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (page_size_sel_reg == 2'h0) |-> (diag_id == 5'h03))
    else $error("diagnostic id wrong for page code 0");
  AST_MASTER_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (own_node_id_reg == time_master_id_reg) |=> master_reg)
    else $error("master status not set");
  AST_PRESET_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (preset_done_reg && !resync) |=> preset_done_reg)
    else $error("preset flag lost without resync");
endmodule // rx_output_node
`default_nettype wire

/* logic/rxnode_pkg.sv */
// Shared constants and types for the standalone receive node
package rxnode_pkg;
  // Clock
  localparam int CLK_HZ = 50_000_000;
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_NODE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_TIME = 5'h0C;
  localparam logic [4:0] OFS_LATCH = 5'h10;
  // Control field positions
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_PAGE_LSB = 4;
  localparam int CTRL_PRE_LSB = 8;
  localparam int CTRL_RESYNC_BIT = 16;
  localparam int NODE_OWN_LSB = 0;
  localparam int NODE_MASTER_LSB = 8;
  localparam int NODE_MAX_LSB = 16;
  // Reset values
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [1:0] PAGE_RST = 2'h3;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [4:0] OWN_ID_RST = 5'h01;
  localparam logic [4:0] MASTER_ID_RST = 5'h01;
  localparam logic [4:0] MAX_ID_RST = 5'h1F;
  // Mode and identifier values
  localparam logic [2:0] TRIG_EXTERNAL = 3'h7;
  localparam logic [4:0] DIAG_MAX_ID = 5'h1F;
  localparam logic [5:0] DIAG_ID_BASE = 6'h04;
  // Counts
  localparam logic [11:0] PRESCALE_BASE = 12'h020;
  localparam logic [3:0] STROBE_LOW_CYCLES = 4'h4;
  localparam logic [8:0] MIN_PKT_BYTES = 9'h008;
  localparam int TAIL_DEPTH = 6;
  // One received byte from the link receiver
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic crc_ok;
    logic [7:0] data;
  } rx_beat_t;
  // Summary of a finished packet
  typedef struct packed {
    logic [7:0] sid;
    logic [7:0] dest_id;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [15:0] time_word;
    logic [7:0] last_byte;
    logic crc_ok;
    logic long_enough;
  } rx_summary_t;
endpackage

/* logic/pkt_tail.sv */
// Keeps the header and last six bytes of the packet being received
`timescale 1ns/10ps
`default_nettype none
module pkt_tail (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Byte stream
  input wire rxnode_pkg::rx_beat_t beat_i,
  // Packet summary
  output logic done_o,
  output rxnode_pkg::rx_summary_t sum_o
);
  import rxnode_pkg::*;

  logic [7:0] tail_reg [0:TAIL_DEPTH-1];
  logic [8:0] count_reg;
  logic [7:0] sid_reg;
  logic [7:0] did_reg;
  logic crc_reg;
  logic done_reg;

  // Tail shift register, newest byte at index 0
  genvar gi;
  generate
    for (gi = 0; gi < TAIL_DEPTH; gi++) begin : g_tail
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          tail_reg[gi] <= 8'h00;
        end else if (beat_i.valid) begin
          tail_reg[gi] <= (gi == 0) ? beat_i.data : tail_reg[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // Header capture, byte count and end marker
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= 9'h000;
      sid_reg <= 8'h00;
      did_reg <= 8'h00;
      crc_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= beat_i.valid && beat_i.last;
      if (beat_i.valid) begin
        count_reg <= beat_i.first ? 9'h001 : count_reg + ((&count_reg) ? 9'h000 : 9'h001);
        if (beat_i.first) sid_reg <= beat_i.data;
        if (!beat_i.first && count_reg == 9'h001) did_reg <= beat_i.data;
        if (beat_i.last) crc_reg <= beat_i.crc_ok;
      end
    end
  end

  // Word pairing: earlier byte is the low byte
  assign sum_o.sid = sid_reg;
  assign sum_o.dest_id = did_reg;
  assign sum_o.word_a = {tail_reg[4], tail_reg[5]};
  assign sum_o.word_b = {tail_reg[2], tail_reg[3]};
  assign sum_o.time_word = {tail_reg[0], tail_reg[1]};
  assign sum_o.last_byte = tail_reg[0];
  assign sum_o.crc_ok = crc_reg;
  assign sum_o.long_enough = count_reg >= MIN_PKT_BYTES;
  assign done_o = done_reg;
endmodule // pkt_tail
`default_nettype wire

/* logic/net_timer.sv */
// Prescaled network time counter with preset and rate trim
`timescale 1ns/10ps
`default_nettype none
module net_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [2:0] prescale_sel_i,
  input wire logic load_i,
  input wire logic [15:0] load_value_i,
  input wire logic slow_i,
  input wire logic fast_i,
  // Time
  output logic [15:0] time_o
);
  import rxnode_pkg::*;

  logic [11:0] pre_reg;
  logic [15:0] time_reg;
  logic skip_reg;
  logic extra_reg;
  wire [11:0] pre_limit = (PRESCALE_BASE << prescale_sel_i) - 12'h001;
  wire tick = (pre_reg >= pre_limit);
  wire [15:0] step = skip_reg ? 16'h0000 : (extra_reg ? 16'h0002 : 16'h0001);

  // Divider and counter; wraps from all ones to zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= 12'h000;
      time_reg <= 16'h0000;
    end else if (load_i) begin
      pre_reg <= 12'h000;
      time_reg <= load_value_i;
    end else begin
      pre_reg <= tick ? 12'h000 : pre_reg + 12'h001;
      if (tick) time_reg <= time_reg + step;
    end
  end

  // Pending trim, a new request beats the tick that consumes the old one
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_reg <= 1'b0;
      extra_reg <= 1'b0;
    end else begin
      skip_reg <= slow_i || (skip_reg && !tick && !fast_i);
      extra_reg <= fast_i || (extra_reg && !tick && !slow_i);
    end
  end

  assign time_o = time_reg;
endmodule // net_timer
`default_nettype wire

/* bench/link_node_model.sv */
// Far-side node model that sends one eight-byte packet on request
`timescale 1ns/10ps
`default_nettype none
module link_node_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Packet request, byte 0 in bits 7:0
  input wire logic start_i,
  input wire logic [63:0] pkt_i,
  input wire logic crc_ok_i,
  // Byte stream
  output rxnode_pkg::rx_beat_t beat_o,
  output logic busy_o
);
  import rxnode_pkg::*;
  logic [2:0] idx_reg;
  // One byte per cycle; idle data toggles so no stale byte lingers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_reg <= 3'h0;
      beat_o <= '0;
      busy_o <= 1'b0;
    end else if (busy_o || start_i) begin
      beat_o.valid <= 1'b1;
      beat_o.first <= (idx_reg == 3'h0);
      beat_o.last <= (idx_reg == 3'h7);
      beat_o.crc_ok <= crc_ok_i;
      beat_o.data <= pkt_i[idx_reg*8 +: 8];
      idx_reg <= idx_reg + 3'h1;
      busy_o <= (idx_reg != 3'h7);
    end else begin
      beat_o.valid <= 1'b0;
      beat_o.first <= 1'b0;
      beat_o.last <= 1'b0;
      beat_o.data <= ~beat_o.data;
    end
  end
endmodule // link_node_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the standalone receive node
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rxnode_pkg::*;
  logic clk, rst_n, rd, wr, waitr, diag_n, flag, foe, tmast, dmode, start, crc, busy;
  logic [4:0] addr, hid;
  logic [31:0] wdata, rdata, q;
  logic [15:0] dout, doe, ntime;
  logic [63:0] pkt;
  rx_beat_t beat;
  int num_errors = 0;
  int total_checks = 0;
  // Clock
  always #10 clk = ~clk;
  rx_output_node uut (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitr), .rx_beat_i(beat), .diag_enable_n_i(diag_n),
    .data_out_lines_o(dout), .data_out_lines_oe_n_o(doe), .flag_latch_out_o(flag),
    .flag_latch_out_oe_n_o(foe), .network_time_o(ntime), .highest_node_id_o(hid),
    .time_master_o(tmast), .diag_mode_o(dmode));
  link_node_model far_node (.sys_clk_i(clk), .rst_n_i(rst_n), .start_i(start),
    .pkt_i(pkt), .crc_ok_i(crc), .beat_o(beat), .busy_o(busy));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("ERROR wait limit");
    results();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Avalon access held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitr !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) hang();
  endtask
  // Packet: sid, did, word copy, word near end, time word
  task automatic send(input logic [7:0] s, d, input logic [15:0] wa, wb, tw, input logic c);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    pkt <= {tw, wb, wa, d, s};
    crc <= c;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 20);
    if (n >= 20) hang();
  endtask
  task automatic t_reset();
    chk("strobe", dout[0], 1'b1);
    rst_n <= 1'b1;
    cyc(2);
    chk("port_oe", doe, 16'hFFFF);
    chk("flag_oe", foe, 1'b1);
    chk("master", tmast, 1'b1);
    bus(0, OFS_CTRL, 0);
    chk("ctrl", q, 32'h00000030);
    bus(0, OFS_NODE, 0);
    chk("node", q, 32'h001F0101);
    bus(1, 5'h14, 32'hFFFFFFFF);
    bus(0, 5'h14, 0);
    chk("unmapped", q, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_accept();
    send(8'h02, 8'h01, 16'hC3A5, 16'hC3A5, 16'h0000, 1);
    cyc(6);
    chk("port", dout, 16'hC3A5);
    chk("port_oe", doe, 16'h0000);
    send(8'h02, 8'h03, 16'h1111, 16'h1111, 16'h0000, 1);
    cyc(6);
    chk("port_did", dout, 16'hC3A5);
    send(8'h02, 8'h01, 16'h2222, 16'h2223, 16'h0000, 1);
    cyc(6);
    chk("port_word", dout, 16'hC3A5);
    send(8'h02, 8'h01, 16'h3333, 16'h3333, 16'h0000, 0);
    cyc(6);
    chk("port_crc", dout, 16'hC3A5);
    bus(0, OFS_LATCH, 0);
    chk("latch", q[15:0], 16'hC3A5);
    $display("test accept done");
  endtask
  task automatic t_strobe();
    int low;
    low = 0;
    bus(1, OFS_CTRL, 32'h00000037);
    cyc(2);
    chk("strobe_up", dout[0], 1'b1);
    chk("strobe_oe", doe[0], 1'b0);
    send(8'h02, 8'h01, 16'h5A5A, 16'h5A5A, 16'h0000, 1);
    repeat (12) begin
      @(posedge clk);
      if (dout[0] === 1'b0) low++;
    end
    chk("strobe_w", low, STROBE_LOW_CYCLES);
    chk("port_hi", dout[15:1], 15'h2D2D);
    chk("strobe_idle", dout[0], 1'b1);
    bus(1, OFS_CTRL, 32'h00000030);
    $display("test strobe done");
  endtask
  task automatic t_flag();
    logic [7:0] ids [4] = '{8'h1F, 8'h0F, 8'h07, 8'h03};
    for (int i = 0; i < 4; i++) begin
      bus(1, OFS_CTRL, (3 - i) << 4);
      send(ids[i], 8'h00, 16'h0000, 16'h0000, {!i[0], 15'h0000}, 1);
      cyc(6);
      chk("flag", flag, !i[0]);
      chk("flag_oe", foe, 1'b0);
    end
    bus(1, OFS_CTRL, 32'h00000030);
    $display("test flag done");
  endtask
  task automatic t_diag();
    bus(1, OFS_NODE, 32'h00050101);
    cyc(4);
    chk("highest", hid, 5'h05);
    diag_n <= 1'b0;
    cyc(6);
    chk("diag", dmode, 1'b1);
    chk("highest_d", hid, DIAG_MAX_ID);
    diag_n <= 1'b1;
    cyc(6);
    chk("highest_n", hid, 5'h05);
    $display("test diag done");
  endtask
  task automatic tick(input logic [15:0] stp, output int n);
    logic [15:0] old;
    old = ntime;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ntime === old && n < 9000);
    if (n >= 9000) hang();
    chk("step", 16'(ntime - old), stp);
  endtask
  task automatic t_prescale();
    int n;
    for (int s = 0; s < 8; s++) begin
      bus(1, OFS_CTRL, 32'h30 | (s << 8));
      tick(16'h0001, n);
      tick(16'h0001, n);
      chk("period", n, 32 << s);
    end
    bus(1, OFS_CTRL, 32'h00000030);
    $display("test prescale done");
  endtask
  task automatic t_time();
    int n;
    bus(1, OFS_NODE, 32'h001F0201);
    cyc(3);
    chk("slave", tmast, 1'b0);
    send(8'h02, 8'h00, 16'h0000, 16'h0000, 16'h1234, 1);
    cyc(4);
    chk("preset", ntime[15:4], 12'h123);
    send(8'h02, 8'h00, 16'h0000, 16'h0000, 16'h8000, 1);
    cyc(2);
    tick(16'h0002, n);
    chk("no_preset", ntime[15:8], 8'h12);
    send(8'h02, 8'h00, 16'h0000, 16'h0000, 16'h1000, 1);
    cyc(2);
    tick(16'h0001, n);
    chk("slow", n > 32, 1'b1);
    bus(1, OFS_CTRL, 32'h00010030);
    send(8'h02, 8'h00, 16'h0000, 16'h0000, 16'hFFFF, 1);
    cyc(70);
    chk("wrap", ntime[15:2], 14'h0000);
    $display("test time done");
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h00000000;
    diag_n = 1'b1;
    start = 1'b0;
    pkt = 64'h0;
    crc = 1'b0;
    cyc(20);
    t_reset();
    t_accept();
    t_strobe();
    t_flag();
    t_diag();
    t_prescale();
    t_time();
    results();
  end
endmodule // tb_top
`default_nettype wire
